// ==== bench/mmp_core_map_bench.sv ====
// self-checking bench for the pc and data map block
`timescale 1ns/100ps
module mmp_core_map_bench;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg instrDone = 1'b0, swIntOp = 1'b0, hwIntReq = 1'b0;
    reg memRead = 1'b0, memWrite = 1'b0, instClkTick = 1'b0;
    reg extClockPin = 1'b0, lowOscTick = 1'b0;
    reg timerAModeSetting = 1'b0, cfgLowOscSel = 1'b0;
    reg [2:0] instrKind = 3'h0;
    reg [9:0] instrTarget = 10'h000;
    reg [1:0] memPage = 2'h3;
    reg [5:0] opLoc = 6'h00, portBPins = 6'h00;
    reg [7:0] wrData = 8'h00;
    wire [9:0] progAddr;
    wire [7:0] rdData, timerACount;
    wire [1:0] bankNumber;
    wire rdValid, pcInPresetCode;
    integer err_total = 0, comparisons = 0, i;
    reg [7:0] lfsr = 8'h46;
    reg [9:0] pc;
    reg [5:0] loc;
    always #2 sys_clk = ~sys_clk;
    mmp_core_map mmp_core_map_i (.sys_clk, .rst, .instrDone, .instrKind,
        .instrTarget, .swIntOp, .hwIntReq, .memRead, .memWrite, .memPage,
        .opLoc, .wrData, .instClkTick, .extClockPin, .lowOscTick,
        .timerAModeSetting, .cfgLowOscSel, .portBPins, .progAddr, .rdData,
        .rdValid, .bankNumber, .timerACount, .pcInPresetCode);
    function [7:0] nxt(input [7:0] s);
        nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task cmp10(input [9:0] got, input [9:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task cmp8(input [7:0] got, input [7:0] exp);
        cmp10({2'h0, got}, {2'h0, exp});
    endtask
    task finish_test;
        begin
            $display("mismatches %0d of %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // one request cycle, outputs sampled mid-cycle once they have settled
    task op(input d, input [2:0] k, input [9:0] t, input s, input h,
            input r, input w, input [1:0] p, input [5:0] l, input [7:0] x);
        begin
            @(posedge sys_clk);
            instrDone <= d;
            instrKind <= k;
            instrTarget <= t;
            swIntOp <= s;
            hwIntReq <= h;
            memRead <= r;
            memWrite <= w;
            memPage <= p;
            opLoc <= l;
            wrData <= x;
            @(posedge sys_clk);
            instrDone <= 1'b0;
            swIntOp <= 1'b0;
            hwIntReq <= 1'b0;
            memRead <= 1'b0;
            memWrite <= 1'b0;
            @(negedge sys_clk);
        end
    endtask
    task ins(input [2:0] k, input [9:0] t);
        op(1'b1, k, t, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 6'h00, 8'h00);
    endtask
    task wr(input [1:0] p, input [5:0] l, input [7:0] x);
        op(1'b0, 3'h0, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1, p, l, x);
    endtask
    task rd(input [1:0] p, input [5:0] l, input [7:0] e);
        begin
            op(1'b0, 3'h0, 10'h000, 1'b0, 1'b0, 1'b1, 1'b0, p, l, 8'h00);
            cmp8(rdValid === 1'b1 ? rdData : 8'hEE, e);
        end
    endtask
    // every source ticks at its own rate so a wrong selection shows
    task pump(input integer n);
        integer c;
        begin
            for (c = 0; c < 4 * n; c = c + 1) begin
                @(posedge sys_clk);
                instClkTick <= 1'b1;
                lowOscTick <= ~c[0];
                extClockPin <= ~c[1];
            end
            @(posedge sys_clk);
            instClkTick <= 1'b0;
            lowOscTick <= 1'b0;
            extClockPin <= 1'b0;
            @(negedge sys_clk);
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total = err_total + 1;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        portBPins <= 6'h2A;
        @(negedge sys_clk);
        cmp10(progAddr, 10'h000);
        pc = 10'h000;
        for (i = 0; i < 6; i = i + 1) begin
            lfsr = nxt(lfsr);
            ins(3'h0, 10'h000);
            cmp10(progAddr, pc + 10'h001);
            ins(3'h6, {lfsr[7], 1'b0, lfsr});
            cmp10(progAddr, {lfsr[7], 1'b0, lfsr});
            ins(3'h7, 10'h000);
            cmp10(progAddr, pc + 10'h002);
            pc = {~lfsr[7], lfsr[0], lfsr};
            if (pc > 10'h3FB) pc = pc - 10'h010;
            ins(3'h5, pc);
            cmp10(progAddr, pc);
        end
        op(1'b1, 3'h0, 10'h000, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 6'h00, 8'h00);
        cmp10(progAddr, 10'h001);
        ins(3'h7, 10'h000);
        cmp10(progAddr, pc + 10'h001);
        op(1'b0, 3'h0, 10'h000, 1'b0, 1'b1, 1'b0, 1'b0, 2'h3, 6'h00, 8'h00);
        cmp10(progAddr, 10'h008);
        ins(3'h7, 10'h000);
        cmp10(progAddr, pc + 10'h001);
        ins(3'h5, 10'h00E);
        cmp8({7'h00, pcInPresetCode}, 8'h01);
        ins(3'h0, 10'h000);
        ins(3'h0, 10'h000);
        cmp8({7'h00, pcInPresetCode}, 8'h00);
        wr(2'h0, 6'h0A, 8'h03);
        ins(3'h1, 10'h0AB);
        cmp10(progAddr, 10'h2AB);
        ins(3'h2, 10'h055);
        cmp10(progAddr, 10'h355);
        ins(3'h7, 10'h000);
        cmp10(progAddr, 10'h2AC);
        op(1'b1, 3'h0, 10'h000, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 6'h02, 8'h9C);
        cmp10(progAddr, 10'h39C);
        wr(2'h0, 6'h0A, 8'h01);
        ins(3'h1, 10'h1F0);
        cmp10(progAddr, 10'h1F0);
        ins(3'h3, 10'h3C7);
        cmp10(progAddr, 10'h1C7);
        ins(3'h4, 10'h212);
        cmp10(progAddr, 10'h112);
        ins(3'h7, 10'h000);
        cmp10(progAddr, 10'h1C8);
        for (i = 0; i < 6; i = i + 1) begin
            lfsr = nxt(lfsr);
            loc = {1'b1, lfsr[4:0]};
            wr(2'h0, 6'h04, {lfsr[7:6], 6'h00});
            wr(2'h0, loc, lfsr ^ 8'h5A);
            cmp8({6'h00, bankNumber}, {6'h00, lfsr[7:6]});
            wr(2'h0, 6'h04, {~lfsr[7:6], loc});
            rd(2'h0, 6'h00, lfsr ^ 8'h5A);
        end
        wr(2'h0, 6'h04, 8'hD0);
        wr(2'h0, 6'h00, 8'hA5);
        rd(2'h0, 6'h10, 8'hA5);
        rd(2'h0, 6'h04, 8'hD0);
        wr(2'h0, 6'h04, 8'h40);
        wr(2'h0, 6'h00, 8'h99);
        rd(2'h0, 6'h00, 8'h00);
        rd(2'h0, 6'h04, 8'h40);
        wr(2'h1, 6'h0C, 8'h3C);
        rd(2'h1, 6'h0C, 8'h3C);
        cmp8({6'h00, bankNumber}, 8'h00);
        rd(2'h0, 6'h0C, 8'h3F);
        wr(2'h2, 6'h03, 8'h77);
        rd(2'h2, 6'h03, 8'h77);
        rd(2'h0, 6'h03, 8'h18);
        wr(2'h0, 6'h05, 8'hFF);
        rd(2'h0, 6'h05, 8'h00);
        wr(2'h0, 6'h06, 8'hC3);
        rd(2'h0, 6'h06, 8'hEA);
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge sys_clk);
            timerAModeSetting <= i > 0;
            cfgLowOscSel <= i == 1;
            wr(2'h0, 6'h01, 8'hF0);
            cmp8(timerACount, 8'hF0);
            pump(3);
            loc = i == 0 ? 6'h0C : i == 1 ? 6'h06 : 6'h03;
            rd(2'h0, 6'h01, 8'hF0 + {2'h0, loc});
        end
        finish_test;
    end
endmodule // mmp_core_map_bench

// ==== bench/mmp_core_map_checker.sv ====
// concurrent checks on the pc and data map block ports
`timescale 1ns/100ps
module mmp_core_map_checker (
    input wire sys_clk,
    input wire rst,
    input wire instrDone,
    input wire [2:0] instrKind,
    input wire [9:0] instrTarget,
    input wire swIntOp,
    input wire hwIntReq,
    input wire memRead,
    input wire memWrite,
    input wire [1:0] memPage,
    input wire [5:0] opLoc,
    input wire [7:0] wrData,
    input wire [9:0] progAddr,
    input wire [7:0] rdData,
    input wire rdValid,
    input wire [1:0] bankNumber,
    input wire [7:0] timerACount
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a low-byte write also moves the pc, so it is kept out of plain events
    wire plain = instrDone && !swIntOp && !hwIntReq && !memWrite;
    wire tmaAcc = memPage == 2'h0 && opLoc == 6'h01;
    sequence s_call;
        plain && instrKind == 3'h6;
    endsequence
    sequence s_gap;
        !instrDone && !hwIntReq;
    endsequence
    sequence s_ret;
        plain && instrKind == 3'h7;
    endsequence
    a_reset_state: assert property (disable iff (1'b0)
        rst |=> progAddr == 10'h000 && !rdValid && bankNumber == 2'h0)
        else $error("reset state wrong");
    a_soft_vector: assert property (instrDone && swIntOp && !hwIntReq
        |=> progAddr == 10'h001) else $error("soft vector wrong");
    a_hard_vector: assert property (hwIntReq
        |=> progAddr == 10'h008) else $error("hard vector wrong");
    a_seq_step: assert property (plain && instrKind == 3'h0
        |=> progAddr == $past(progAddr) + 10'h001)
        else $error("pc step wrong");
    a_short_jump: assert property (plain && instrKind == 3'h1
        |=> progAddr[8:0] == $past(instrTarget[8:0]))
        else $error("short jump wrong");
    a_short_call: assert property (plain && instrKind == 3'h2
        |=> progAddr[7:0] == $past(instrTarget[7:0]))
        else $error("short call wrong");
    a_page_load: assert property (plain &&
        instrKind inside {3'h3, 3'h4}
        |=> progAddr[7:0] == $past(instrTarget[7:0]))
        else $error("page load wrong");
    a_long_load: assert property (plain &&
        instrKind inside {3'h5, 3'h6} |=> progAddr == $past(instrTarget))
        else $error("long load wrong");
    a_call_return: assert property (s_call ##1 s_gap ##1 s_ret
        |=> progAddr == $past(progAddr, 3) + 10'h001)
        else $error("return address wrong");
    a_page_bank: assert property ((memRead || memWrite) &&
        memPage inside {2'h1, 2'h2} |=> bankNumber == 2'h0)
        else $error("page bank wrong");
    a_timer_write: assert property (memWrite && tmaAcc
        |=> timerACount == $past(wrData)) else $error("timer write wrong");
    a_timer_read: assert property (memRead && tmaAcc
        |=> rdValid && rdData == $past(timerACount))
        else $error("timer read wrong");
endmodule // mmp_core_map_checker

bind mmp_core_map mmp_core_map_checker mmp_core_map_checker_i (
    .sys_clk, .rst, .instrDone, .instrKind, .instrTarget, .swIntOp,
    .hwIntReq, .memRead, .memWrite, .memPage, .opLoc, .wrData,
    .progAddr, .rdData, .rdValid, .bankNumber, .timerACount);

// ==== pkg/mmp_consts.vh ====
// constants for the program counter and data memory map block
`ifndef MMP_CONSTS_VH
`define MMP_CONSTS_VH

// ----------------------------------------------------------------
// program space
// ----------------------------------------------------------------
`define MMP_PC_W 10
`define MMP_VEC_RESET 10'h000
`define MMP_VEC_SOFT 10'h001
`define MMP_VEC_HARD 10'h008
`define MMP_PRESET_LO 10'h00E
`define MMP_PRESET_HI 10'h00F
`define MMP_STACK_DEPTH 8
`define MMP_SP_W 3

// instruction kinds reported by the decoder
`define MMP_K_SEQ 3'h0
`define MMP_K_SHORT_JUMP 3'h1
`define MMP_K_SHORT_CALL 3'h2
`define MMP_K_PAGE_JUMP 3'h3
`define MMP_K_PAGE_CALL 3'h4
`define MMP_K_LONG_JUMP 3'h5
`define MMP_K_LONG_CALL 3'h6
`define MMP_K_RETURN 3'h7

// ----------------------------------------------------------------
// data space
// ----------------------------------------------------------------
`define MMP_PAGE_R 2'h0
`define MMP_PAGE_F 2'h1
`define MMP_PAGE_S 2'h2
`define MMP_LOC_IDP 6'h00
`define MMP_LOC_TMA 6'h01
`define MMP_LOC_PCLO 6'h02
`define MMP_LOC_STAT 6'h03
`define MMP_LOC_FSP 6'h04
`define MMP_LOC_PBD 6'h06
`define MMP_LOC_PWR 6'h08
`define MMP_LOC_WAKE 6'h09
`define MMP_LOC_PCHB 6'h0A
`define MMP_LOC_PDN 6'h0B
`define MMP_LOC_PUP 6'h0C
`define MMP_LOC_IEN 6'h0E
`define MMP_LOC_IFL 6'h0F
`define MMP_RAM_BASE 6'h10
`define MMP_RAM_WORDS 48
`define MMP_PAGE_WORDS 16
`define MMP_BANK_HI 7
`define MMP_BANK_LO 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MMP_RST_STAT 8'h18
`define MMP_RST_PWR 8'h88
`define MMP_RST_WAKE 8'h3F
`define MMP_RST_PDN 8'hFF
`define MMP_RST_PUP 8'h3F
`define MMP_PCHB_MASK 8'h07

`endif

// ==== verilog/mmp_core_map.v ====
// program counter sequencing and data memory address decoding
`timescale 1ns/100ps
`include "mmp_consts.vh"

module mmp_core_map (
    input wire sys_clk,
    input wire rst,
    input wire instrDone,
    input wire [2:0] instrKind,
    input wire [9:0] instrTarget,
    input wire swIntOp,
    input wire hwIntReq,
    input wire memRead,
    input wire memWrite,
    input wire [1:0] memPage,
    input wire [5:0] opLoc,
    input wire [7:0] wrData,
    input wire instClkTick,
    input wire extClockPin,
    input wire lowOscTick,
    input wire timerAModeSetting,
    input wire cfgLowOscSel,
    input wire [5:0] portBPins,
    output wire [9:0] progAddr,
    output wire [7:0] rdData,
    output wire rdValid,
    output wire [1:0] bankNumber,
    output wire [7:0] timerACount,
    output wire pcInPresetCode
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [9:0] pc_r;
reg [9:0] pc_nxt;
reg [2:0] sp_r;
reg [2:0] sp_nxt;
reg push;
reg [9:0] pushVal;
reg [7:0] tma_r;
reg [7:0] stat_r;
reg [7:0] fsp_r;
reg [7:0] pbd_r;
reg [7:0] pwr_r;
reg [7:0] wake_r;
reg [7:0] pchb_r;
reg [7:0] pdn_r;
reg [7:0] pup_r;
reg [7:0] ien_r;
reg [7:0] ifl_r;
reg [7:0] rdData_r;
reg rdValid_r;
reg [1:0] bank_r;
reg preset_r;
reg extPrev_r;
reg extArm_r;
reg [7:0] rdMux;
reg [9:0] stack_r [0:7];
reg [7:0] ram_r [0:47];
reg [7:0] fPage_r [0:15];
reg [7:0] sPage_r [0:15];

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire isR = (memPage == `MMP_PAGE_R);
wire isF = (memPage == `MMP_PAGE_F);
wire isS = (memPage == `MMP_PAGE_S);
// location zero never holds data, it names the pointer target
wire viaPort = isR && (opLoc == `MMP_LOC_IDP);
wire [5:0] rLoc = viaPort ? fsp_r[5:0] : opLoc;
wire [1:0] effBank = fsp_r[`MMP_BANK_HI:`MMP_BANK_LO];
// banks 1..3 alias to bank 0, so the bank never reaches the index
wire [5:0] physLoc = rLoc;
wire isRam = (physLoc >= `MMP_RAM_BASE);
wire [5:0] ramIdx = physLoc - `MMP_RAM_BASE;
// extra pages take their index straight from the opcode
wire [3:0] pageIdx = opLoc[3:0];
wire wrR = memWrite && isR;
wire wrPcl = wrR && (physLoc == `MMP_LOC_PCLO);
wire wrTma = wrR && (physLoc == `MMP_LOC_TMA);
// ram locations never match a special register, keep them out early
wire wrSpecial = wrR && !isRam;

// ----------------------------------------------------------------
// program counter and stack
// ----------------------------------------------------------------
wire [9:0] pcInc = pc_r + 10'h001;
wire [2:0] spDec = sp_r - 3'h1;
// candidate loads for short jumps, page loads, low-byte writes and returns
wire [9:0] shortJumpPc = {pchb_r[1], instrTarget[8:0]};
wire [9:0] pagePc = {pchb_r[1:0], instrTarget[7:0]};
wire [9:0] pclPc = {pchb_r[1:0], wrData};
wire [9:0] popPc = stack_r[spDec];

always @* begin
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    push = 1'b0;
    pushVal = pcInc;
    if (hwIntReq) begin
        // current address has not executed yet, so it is the return point
        push = 1'b1;
        pushVal = pc_r;
        pc_nxt = `MMP_VEC_HARD;
    end else if (instrDone && swIntOp) begin
        push = 1'b1;
        pc_nxt = `MMP_VEC_SOFT;
    end else if (instrDone) begin
        case (instrKind)
            `MMP_K_SHORT_JUMP: begin
                pc_nxt = shortJumpPc;
            end
            `MMP_K_SHORT_CALL, `MMP_K_PAGE_CALL: begin
                pc_nxt = pagePc;
                push = 1'b1;
            end
            `MMP_K_PAGE_JUMP: begin
                // same 256-word reach as a short call, without the push
                pc_nxt = pagePc;
            end
            `MMP_K_LONG_JUMP: begin
                pc_nxt = instrTarget;
            end
            `MMP_K_LONG_CALL: begin
                pc_nxt = instrTarget;
                push = 1'b1;
            end
            `MMP_K_RETURN: begin
                pc_nxt = popPc;
                sp_nxt = spDec;
            end
            default: begin
                // a write to the low byte is a direct load, not a step
                if (wrPcl) begin
                    pc_nxt = pclPc;
                end else begin
                    pc_nxt = pcInc;
                end
            end
        endcase
    end
    if (push) begin
        sp_nxt = sp_r + 3'h1;
    end
end

// preset words are ordinary program space once released
wire nxtInPreset = (pc_nxt == `MMP_PRESET_LO) ||
    (pc_nxt == `MMP_PRESET_HI);

always @(posedge sys_clk) begin
    if (rst) begin
        pc_r <= `MMP_VEC_RESET;
        sp_r <= 3'h0;
        preset_r <= 1'b0;
    end else begin
        pc_r <= pc_nxt;
        sp_r <= sp_nxt;
        preset_r <= nxtInPreset;
    end
end

// ----------------------------------------------------------------
// hardware stack
// ----------------------------------------------------------------
// eight levels wrap silently; deeper nesting overwrites the oldest
genvar gi;
generate
    for (gi = 0; gi < `MMP_STACK_DEPTH; gi = gi + 1) begin : gStack
        always @(posedge sys_clk) begin
            if (rst) begin
                stack_r[gi] <= 10'h000;
            end else if (push && (sp_r == gi)) begin
                stack_r[gi] <= pushVal;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// timer A count
// ----------------------------------------------------------------
wire extRise = extArm_r && extClockPin && !extPrev_r;
wire srcTick = timerAModeSetting ?
    (cfgLowOscSel ? lowOscTick : extRise) : instClkTick;

// the detector sits out the first cycle after reset, so a pin that is
// already high when reset lifts is not taken for a rising edge
always @(posedge sys_clk) begin
    if (rst) begin
        extPrev_r <= 1'b0;
        extArm_r <= 1'b0;
    end else begin
        extPrev_r <= extClockPin;
        extArm_r <= 1'b1;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        tma_r <= 8'h00;
    end else begin
        // software write beats a tick landing in the same cycle
        if (wrTma) begin
            tma_r <= wrData;
        end else if (srcTick) begin
            tma_r <= tma_r + 8'h01;
        end
    end
end

// ----------------------------------------------------------------
// special registers
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
    if (rst) begin
        stat_r <= `MMP_RST_STAT;
        fsp_r <= 8'h00;
        pbd_r <= 8'h00;
        pwr_r <= `MMP_RST_PWR;
        wake_r <= `MMP_RST_WAKE;
        pchb_r <= 8'h00;
        pdn_r <= `MMP_RST_PDN;
        pup_r <= `MMP_RST_PUP;
        ien_r <= 8'h00;
        ifl_r <= 8'h00;
        bank_r <= 2'h0;
    end else begin
        if (memRead || memWrite) begin
            // extra pages ignore the bank bits, report bank 0 for them
            bank_r <= isR ? effBank : 2'h0;
        end
        if (wrSpecial) begin
            case (physLoc)
                // pointer aimed at the port itself: the write is dropped
                `MMP_LOC_IDP: begin
                end
                // timer and pc low byte load in their own processes
                `MMP_LOC_STAT: stat_r <= wrData;
                `MMP_LOC_FSP: fsp_r <= wrData;
                `MMP_LOC_PBD: pbd_r <= wrData;
                `MMP_LOC_PWR: pwr_r <= wrData;
                `MMP_LOC_WAKE: wake_r <= wrData;
                `MMP_LOC_PCHB: pchb_r <= wrData & `MMP_PCHB_MASK;
                `MMP_LOC_PDN: pdn_r <= wrData;
                `MMP_LOC_PUP: pup_r <= wrData;
                `MMP_LOC_IEN: ien_r <= wrData;
                `MMP_LOC_IFL: ifl_r <= wrData;
                default: begin
                end
            endcase
        end
    end
end

// ----------------------------------------------------------------
// general ram and extra pages
// ----------------------------------------------------------------
generate
    for (gi = 0; gi < `MMP_RAM_WORDS; gi = gi + 1) begin : gRam
        always @(posedge sys_clk) begin
            if (rst) begin
                ram_r[gi] <= 8'h00;
            end else if (wrR && isRam && (ramIdx == gi)) begin
                ram_r[gi] <= wrData;
            end
        end
    end
    for (gi = 0; gi < `MMP_PAGE_WORDS; gi = gi + 1) begin : gPage
        always @(posedge sys_clk) begin
            if (rst) begin
                fPage_r[gi] <= 8'h00;
                sPage_r[gi] <= 8'h00;
            end else begin
                // only the dedicated transfer operations select these pages
                if (memWrite && isF && (pageIdx == gi)) begin
                    fPage_r[gi] <= wrData;
                end
                if (memWrite && isS && (pageIdx == gi)) begin
                    sPage_r[gi] <= wrData;
                end
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
always @* begin
    rdMux = 8'h00;
    if (isF) begin
        rdMux = fPage_r[pageIdx];
    end else if (isS) begin
        rdMux = sPage_r[pageIdx];
    end else if (isR && isRam) begin
        rdMux = ram_r[ramIdx];
    end else if (isR) begin
        case (physLoc)
            // pointer back at the port itself finds nothing to read
            `MMP_LOC_IDP: rdMux = 8'h00;
            `MMP_LOC_TMA: rdMux = tma_r;
            `MMP_LOC_PCLO: rdMux = pc_r[7:0];
            `MMP_LOC_STAT: rdMux = stat_r;
            `MMP_LOC_FSP: rdMux = fsp_r;
            `MMP_LOC_PBD: rdMux = {pbd_r[7:6], portBPins};
            `MMP_LOC_PWR: rdMux = pwr_r;
            `MMP_LOC_WAKE: rdMux = wake_r;
            // buffer bits 1:0 are write only and read back as zero
            `MMP_LOC_PCHB: rdMux = {5'h00, pchb_r[2], 2'h0};
            `MMP_LOC_PDN: rdMux = pdn_r;
            `MMP_LOC_PUP: rdMux = pup_r;
            `MMP_LOC_IEN: rdMux = ien_r;
            `MMP_LOC_IFL: rdMux = ifl_r;
            default: rdMux = 8'h00;
        endcase
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        rdData_r <= 8'h00;
        rdValid_r <= 1'b0;
    end else begin
        rdValid_r <= memRead;
        if (memRead) begin
            rdData_r <= rdMux;
        end
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign progAddr = pc_r;
assign rdData = rdData_r;
assign rdValid = rdValid_r;
assign bankNumber = bank_r;
assign timerACount = tma_r;
assign pcInPresetCode = preset_r;

endmodule // mmp_core_map
